// ### verilog/tmr_cfg.svh
// Constants for the 8-bit period/PWM timer: register indices, fields.
// Assumes inclusion by the timer package and modules only.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define TMR_ADDR_CONTROL  2'h0
`define TMR_ADDR_SCALER   2'h1
`define TMR_ADDR_COUNT    2'h2
`define TMR_ADDR_BOUND    2'h3
`define TMR_CLKSEL_HI     7
`define TMR_CLKSEL_LO     4
`define TMR_PINSEL_HI     3
`define TMR_PINSEL_LO     2
`define TMR_MODE_BIT      1
`define TMR_GATE_BIT      0
`define TMR_SIXBIT_BIT    7
`define TMR_PRESC_HI      6
`define TMR_PRESC_LO      5
`define TMR_SCALE_HI      4
`define TMR_SCALE_LO      0
`define TMR_SRC_SYSCLK    4'h1
`define TMR_SRC_FASTRC    4'h2
`define TMR_SRC_SLOWRC    4'h3
`define TMR_SRC_PIN0      4'h4
`define TMR_SRC_PIN1      4'h5
`define TMR_SRC_PIN2      4'h6
`define TMR_SRC_COMP      4'h7
`define TMR_FULL8         8'hFF
`define TMR_FULL6         8'h3F
`define TMR_RESET_REG     8'h00
`endif

// ### verilog/tmr_pkg.sv
// Types shared by the timer modules.
// Assumes tmr_cfg.svh is on the include path.
`include "tmr_cfg.svh"
package tmr_pkg;
    typedef enum logic [1:0] {
        TMR_PRE_DIV1,
        TMR_PRE_DIV4,
        TMR_PRE_DIV16,
        TMR_PRE_DIV64
    } tmr_presc_t;
    typedef enum logic {
        TMR_MODE_PERIOD,
        TMR_MODE_PWM
    } tmr_mode_t;
endpackage : tmr_pkg

// ### verilog/tmr_divider.sv
// Prescaler (1/4/16/64) and scaler (1..32) producing a counting tick.
// Assumes src_tick_i is a one-cycle pulse per selected source edge.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_divider
    import tmr_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       src_tick_i,
    input  wire logic [1:0] presc_i,
    input  wire logic [4:0] scale_i,
    output logic            count_tick_o
);
    logic [5:0] pre_cnt;
    logic [5:0] next_pre_cnt;
    logic [4:0] scl_cnt;
    logic [4:0] next_scl_cnt;
    logic       pre_tick;
    logic [5:0] pre_top;

    always_comb begin
        case (tmr_presc_t'(presc_i))
            TMR_PRE_DIV1:  pre_top = 6'h00;
            TMR_PRE_DIV4:  pre_top = 6'h03;
            TMR_PRE_DIV16: pre_top = 6'h0F;
            default:       pre_top = 6'h3F;
        endcase
        pre_tick     = src_tick_i && (pre_cnt >= pre_top); // see RULE4
        next_pre_cnt = pre_cnt;
        if (src_tick_i) begin
            next_pre_cnt = pre_tick ? 6'h00 : pre_cnt + 6'h01;
        end
        count_tick_o = pre_tick && (scl_cnt >= scale_i); // see RULE5
        next_scl_cnt = scl_cnt;
        if (pre_tick) begin
            next_scl_cnt = count_tick_o ? 5'h00 : scl_cnt + 5'h01;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pre_cnt <= 6'h00;
            scl_cnt <= 5'h00;
        end else if (ce_i) begin
            pre_cnt <= next_pre_cnt;
            scl_cnt <= next_scl_cnt;
        end
    end

    a_tick_needs_pre : assert property (@(posedge clock_i) disable iff (rst_i)
        count_tick_o |-> pre_tick && src_tick_i) // see RULE5
        else $error("count tick without prescaled tick");
    a_div4_spacing : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && presc_i == 2'h1 && $stable(presc_i) && pre_tick)
        |-> pre_cnt == 6'h03) // see RULE4
        else $error("divide by four ticked at wrong count");
endmodule : tmr_divider

// ### verilog/tmr_timer.sv
// 8-bit up-counting timer with period and PWM modes, one instance.
// Assumes synchronous inputs; source clocks arrive as levels sampled
// on clock_i and are edge detected here.
// Overview of operation
// RULE1 - Control upper nibble selects counting clock source
// RULE2 - Control bits 3:2 route output to pin
// RULE3 - Selected pin driven regardless of direction
// RULE4 - Prescaler divides by 1, 4, 16, 64
// RULE5 - Scaler divides by field plus one
// RULE6 - Counter counts up only, eight bits
// RULE7 - Count register write loads, read returns count
// RULE8 - Period mode clears counter at bound
// RULE9 - Control bit 1 selects PWM mode
// RULE10 - Period mode output is 50% square
// RULE11 - Period mode emits one event per period
// RULE12 - 8-bit PWM: period 256, high bound+1
// RULE13 - 6-bit PWM: period 64, high bound+1
// RULE14 - Bound at full scale holds output high
// RULE15 - Comparator high suppresses PWM when gated
// RULE16 - Fast RC keeps clocking during emulator halt
// RULE17 - Bound register sets period or duty
// RULE18 - Parameterized for a second instance
// RULE19 - PWM high while count at or below bound
// RULE20 - Period output toggles at each wrap
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_timer
    import tmr_pkg::*;
#(
    parameter int PIN_COUNT = 3 // see RULE18
)
(
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic [1:0]           addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [7:0]           rdata_o,
    input  wire logic                 debug_halt_i,
    input  wire logic                 internal_fast_rc_i,
    input  wire logic                 internal_slow_rc_i,
    input  wire logic [2:0]           ext_clock_pin_i,
    input  wire logic                 comparator_i,
    input  wire logic                 comparator_gating_option_i,
    output logic      [PIN_COUNT-1:0] pin_out_o,
    output logic      [PIN_COUNT-1:0] pin_oe_o,
    output logic                      period_event_o,
    output logic                      timer_out_o
);
    logic [7:0] timer_control;
    logic [7:0] timer_scaler;
    logic [7:0] timer_count;
    logic [7:0] timer_bound;
    logic [7:0] next_control;
    logic [7:0] next_scaler;
    logic [7:0] next_count;
    logic [7:0] next_bound;
    logic [7:0] next_rdata;
    logic       wave;
    logic       next_wave;
    logic       next_event;
    logic       src_level;
    logic       src_prev;
    logic       src_tick;
    logic       src_run;
    logic       count_tick;
    logic       run_ce;
    logic [3:0] clk_sel;
    tmr_mode_t  mode;
    logic       six_bit;
    logic [7:0] pwm_full;
    logic [7:0] pwm_pos;
    logic       pwm_level;
    logic       out_level;

    assign clk_sel = timer_control[`TMR_CLKSEL_HI:`TMR_CLKSEL_LO];
    assign mode    = tmr_mode_t'(timer_control[`TMR_MODE_BIT]); // see RULE9
    assign six_bit = timer_scaler[`TMR_SIXBIT_BIT];

    // Source selection; unlisted codes stop the timer.
    always_comb begin
        src_level = 1'b0;
        src_run   = 1'b1;
        if (clk_sel == `TMR_SRC_SYSCLK) begin // see RULE1
            src_level = 1'b1;
        end else if (clk_sel == `TMR_SRC_FASTRC) begin
            src_level = internal_fast_rc_i;
        end else if (clk_sel == `TMR_SRC_SLOWRC) begin
            src_level = internal_slow_rc_i;
        end else if (clk_sel == `TMR_SRC_PIN0) begin
            src_level = ext_clock_pin_i[0];
        end else if (clk_sel == `TMR_SRC_PIN1) begin
            src_level = ext_clock_pin_i[1];
        end else if (clk_sel == `TMR_SRC_PIN2) begin
            src_level = ext_clock_pin_i[2];
        end else if (clk_sel == `TMR_SRC_COMP) begin
            src_level = comparator_i;
        end else begin
            src_run = 1'b0;
        end
    end

    // System clock ticks every cycle; other sources on rising edges.
    assign src_tick = src_run &&
        ((clk_sel == `TMR_SRC_SYSCLK) || (src_level && !src_prev));

    // Halt freezes counting unless the fast RC feeds the timer.
    assign run_ce = ce_i && (!debug_halt_i || clk_sel == `TMR_SRC_FASTRC); // see RULE16

    tmr_divider u_div (
        .clock_i      (clock_i),
        .rst_i        (rst_i),
        .ce_i         (run_ce),
        .src_tick_i   (src_tick),
        .presc_i      (timer_scaler[`TMR_PRESC_HI:`TMR_PRESC_LO]),
        .scale_i      (timer_scaler[`TMR_SCALE_HI:`TMR_SCALE_LO]),
        .count_tick_o (count_tick)
    );

    assign pwm_full = six_bit ? `TMR_FULL6 : `TMR_FULL8; // see RULE12
    assign pwm_pos  = timer_count & pwm_full; // see RULE13

    always_comb begin
        next_control = timer_control;
        next_scaler  = timer_scaler;
        next_bound   = timer_bound;
        next_count   = timer_count;
        next_wave    = wave;
        next_event   = 1'b0;
        next_rdata   = 8'h00;
        if (run_ce && count_tick) begin
            if (mode == TMR_MODE_PERIOD && timer_count >= timer_bound) begin
                next_count = 8'h00; // see RULE8
                next_wave  = !wave; // see RULE20
                next_event = 1'b1; // see RULE11
            end else begin
                next_count = timer_count + 8'h01; // see RULE6
            end
        end
        if (wr_i) begin
            if (addr_i == `TMR_ADDR_CONTROL) begin
                next_control = wdata_i;
            end else if (addr_i == `TMR_ADDR_SCALER) begin
                next_scaler = wdata_i;
            end else if (addr_i == `TMR_ADDR_COUNT) begin
                next_count = wdata_i; // see RULE7
            end else begin
                next_bound = wdata_i; // see RULE17
            end
        end
        if (rd_i) begin
            if (addr_i == `TMR_ADDR_CONTROL) begin
                next_rdata = timer_control;
            end else if (addr_i == `TMR_ADDR_SCALER) begin
                next_rdata = timer_scaler;
            end else if (addr_i == `TMR_ADDR_COUNT) begin
                next_rdata = timer_count; // see RULE7
            end else begin
                next_rdata = timer_bound;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            timer_control  <= `TMR_RESET_REG;
            timer_scaler   <= `TMR_RESET_REG;
            timer_count    <= `TMR_RESET_REG;
            timer_bound    <= `TMR_RESET_REG;
            wave           <= 1'b0;
            period_event_o <= 1'b0;
            rdata_o        <= 8'h00;
            src_prev       <= 1'b0;
        end else if (ce_i) begin
            timer_control  <= next_control;
            timer_scaler   <= next_scaler;
            timer_count    <= next_count;
            timer_bound    <= next_bound;
            wave           <= next_wave;
            period_event_o <= next_event;
            rdata_o        <= next_rdata;
            src_prev       <= src_level;
        end
    end

    // Bound above the 6-bit range still compares in full, so it holds high.
    always_comb begin
        pwm_level = (timer_bound >= pwm_full) || (pwm_pos <= timer_bound); // see RULE14
        if (comparator_gating_option_i && timer_control[`TMR_GATE_BIT] && comparator_i) begin
            pwm_level = 1'b0; // see RULE15
        end
        out_level = (mode == TMR_MODE_PWM) ? pwm_level : wave; // see RULE10
    end

    // Output level is combinational from registers and the comparator gating inputs.
    assign timer_out_o = out_level; // see RULE19

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            // Code 0 leaves all pins to the port; 1..N pick a pin.
            assign pin_oe_o[g]  = (timer_control[`TMR_PINSEL_HI:`TMR_PINSEL_LO]
                                   == 2'(g + 1)); // see RULE2
            assign pin_out_o[g] = pin_oe_o[g] && out_level; // see RULE3
        end
    endgenerate

    a_period_wrap : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !wr_i && run_ce && count_tick && mode == TMR_MODE_PERIOD
         && timer_count >= timer_bound) |=> timer_count == 8'h00) // see RULE8
        else $error("period mode did not clear at bound");
    a_event_toggle : assert property (@(posedge clock_i) disable iff (rst_i)
        period_event_o && $past(ce_i) |-> wave != $past(wave)) // see RULE20
        else $error("event without output toggle");
    a_count_up : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !wr_i && run_ce && count_tick && mode == TMR_MODE_PWM)
        |=> timer_count == $past(timer_count) + 8'h01) // see RULE6
        else $error("counter did not step up");
    a_count_load : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == `TMR_ADDR_COUNT) |=> timer_count == $past(wdata_i)) // see RULE7
        else $error("count write not loaded");
    a_read_count : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && rd_i && addr_i == `TMR_ADDR_COUNT) |=> rdata_o == $past(timer_count)) // see RULE7
        else $error("count read wrong");
    a_full_high : assert property (@(posedge clock_i) disable iff (rst_i)
        (mode == TMR_MODE_PWM && timer_bound == `TMR_FULL8 && !comparator_i)
        |-> timer_out_o) // see RULE14
        else $error("full scale pwm not high");
    a_gate_low : assert property (@(posedge clock_i) disable iff (rst_i)
        (mode == TMR_MODE_PWM && comparator_gating_option_i
         && timer_control[`TMR_GATE_BIT] && comparator_i) |-> !timer_out_o) // see RULE15
        else $error("gated pwm not suppressed");
    a_pwm_low : assert property (@(posedge clock_i) disable iff (rst_i)
        (mode == TMR_MODE_PWM && !six_bit && timer_count > timer_bound) |-> !timer_out_o) // see RULE12
        else $error("pwm high past bound");
    a_pin_drive : assert property (@(posedge clock_i) disable iff (rst_i)
        (timer_control[`TMR_PINSEL_HI:`TMR_PINSEL_LO] == 2'h1)
        |-> pin_oe_o[0] && pin_out_o[0] == timer_out_o) // see RULE3
        else $error("selected pin not driven");

    // Register bus: loads land next cycle, read data stands one cycle
    a_rdata_idle : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !rd_i) |=> rdata_o == 8'h00) // see RULE7
        else $error("read data not idle");

    a_read_ctrl : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && rd_i && addr_i == `TMR_ADDR_CONTROL) |=> rdata_o == $past(timer_control)) // see RULE9
        else $error("control read wrong");

    a_read_scaler : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && rd_i && addr_i == `TMR_ADDR_SCALER) |=> rdata_o == $past(timer_scaler)) // see RULE4
        else $error("scaler read wrong");

    a_read_bound : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && rd_i && addr_i == `TMR_ADDR_BOUND) |=> rdata_o == $past(timer_bound)) // see RULE17
        else $error("bound read wrong");

    a_ctrl_load : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == `TMR_ADDR_CONTROL) |=> timer_control == $past(wdata_i)) // see RULE9
        else $error("control write not loaded");

    a_scaler_load : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == `TMR_ADDR_SCALER) |=> timer_scaler == $past(wdata_i)) // see RULE4
        else $error("scaler write not loaded");

    a_bound_load : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == `TMR_ADDR_BOUND) |=> timer_bound == $past(wdata_i)) // see RULE17
        else $error("bound write not loaded");

    // Counting: nothing moves without a counting tick
    a_count_hold : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !wr_i && !(run_ce && count_tick)) |=> timer_count == $past(timer_count)) // see RULE6
        else $error("count moved without tick");

    a_halt_freeze : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !wr_i && debug_halt_i && clk_sel != `TMR_SRC_FASTRC)
        |=> timer_count == $past(timer_count)) // see RULE16
        else $error("count moved during halt");

    a_stop_source : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !wr_i && !src_run) |=> timer_count == $past(timer_count)) // see RULE1
        else $error("stopped source still counts");

    a_sys_tick : assert property (@(posedge clock_i) disable iff (rst_i)
        (clk_sel == `TMR_SRC_SYSCLK) |-> src_tick) // see RULE1
        else $error("system clock source missed a tick");

    a_wave_hold : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !(run_ce && count_tick)) |=> wave == $past(wave)) // see RULE20
        else $error("wave toggled without tick");

    a_event_cause : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !(run_ce && count_tick)) |=> !period_event_o) // see RULE11
        else $error("event without tick");

    a_pwm_no_event : assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && mode == TMR_MODE_PWM) |=> !period_event_o) // see RULE9
        else $error("event in pwm mode");

    // Output shaping
    a_six_pos : assert property (@(posedge clock_i) disable iff (rst_i)
        six_bit |-> pwm_pos <= `TMR_FULL6) // see RULE13
        else $error("six bit position out of range");

    a_pwm_high : assert property (@(posedge clock_i) disable iff (rst_i)
        (mode == TMR_MODE_PWM && pwm_pos <= timer_bound
         && !(comparator_gating_option_i && timer_control[`TMR_GATE_BIT] && comparator_i))
        |-> timer_out_o) // see RULE19
        else $error("pwm low within bound");

    a_period_out : assert property (@(posedge clock_i) disable iff (rst_i)
        (mode == TMR_MODE_PERIOD) |-> timer_out_o == wave) // see RULE10
        else $error("period output not the wave");

    a_pin_off : assert property (@(posedge clock_i) disable iff (rst_i)
        (timer_control[`TMR_PINSEL_HI:`TMR_PINSEL_LO] == 2'h0) |-> pin_oe_o == '0) // see RULE2
        else $error("pin driven with no pin selected");
endmodule : tmr_timer

// ### test/tmr_far_model.sv
// Far side of one timer: source clock levels, comparator, pulled-up pins.
// Assumes a 10 ns system clock; every rate is an exact multiple of it.
`timescale 1ns/1ps
module tmr_far_model (
    input  wire logic       comp_toggle_i,
    input  wire logic       comp_level_i,
    input  wire logic [2:0] pin_out_i,
    input  wire logic [2:0] pin_oe_i,
    output logic            fast_rc_o,
    output logic            slow_rc_o,
    output logic      [2:0] ext_pin_o,
    output logic            comparator_o,
    output logic      [2:0] pin_level_o
);
    logic comp_osc;

    // 2 ns offset keeps source edges clear of the sampling edge
    initial begin
        fast_rc_o = 1'b0;
        #2;
        forever #20 fast_rc_o = ~fast_rc_o;
    end
    initial begin
        slow_rc_o = 1'b0;
        #2;
        forever #120 slow_rc_o = ~slow_rc_o;
    end
    initial begin
        ext_pin_o[0] = 1'b0;
        #2;
        forever #40 ext_pin_o[0] = ~ext_pin_o[0];
    end
    initial begin
        ext_pin_o[1] = 1'b0;
        #2;
        forever #80 ext_pin_o[1] = ~ext_pin_o[1];
    end
    initial begin
        ext_pin_o[2] = 1'b0;
        #2;
        forever #160 ext_pin_o[2] = ~ext_pin_o[2];
    end
    initial begin
        comp_osc = 1'b0;
        #2;
        forever #240 comp_osc = ~comp_osc;
    end
    assign comparator_o = comp_toggle_i ? comp_osc : comp_level_i;
    // Released pins float to the external pull-up level
    assign pin_level_o = (pin_oe_i & pin_out_i) | ~pin_oe_i;
endmodule : tmr_far_model

// ### test/tmr_timer_tb.sv
// Bench for one timer: registers, rates, PWM, gating, pins, sources.
// Assumes the far-side model makes source clocks at fixed exact rates.
`timescale 1ns/1ps
module tmr_timer_tb;
    import tmr_pkg::*;
    logic        clock_i, rst_i, wr_i, rd_i, halt, gate_opt, comp_tog, comp_lvl;
    logic        fast_rc, slow_rc, comp, ev, tout, ce;
    logic [1:0]  addr_i;
    logic [7:0]  wdata_i, rdata_o;
    logic [2:0]  pin_out, pin_oe, ext_pin, pin_level;
    logic [15:0] hi, evs;
    int          miscompares = 0;
    int          compares = 0;
    int          cycles = 0;

    tmr_timer dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .debug_halt_i(halt), .internal_fast_rc_i(fast_rc), .internal_slow_rc_i(slow_rc),
        .ext_clock_pin_i(ext_pin), .comparator_i(comp),
        .comparator_gating_option_i(gate_opt), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .period_event_o(ev), .timer_out_o(tout));
    tmr_far_model far (.comp_toggle_i(comp_tog), .comp_level_i(comp_lvl),
        .pin_out_i(pin_out), .pin_oe_i(pin_oe), .fast_rc_o(fast_rc), .slow_rc_o(slow_rc),
        .ext_pin_o(ext_pin), .comparator_o(comp), .pin_level_o(pin_level));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd
    // Count is cleared last so a smaller bound never starts below the count
    task automatic cfg(input logic [7:0] ctrl, input logic [7:0] scal, input logic [7:0] k);
        wr(2'h0, ctrl);
        wr(2'h1, scal);
        wr(2'h3, k);
        wr(2'h2, 8'h00);
        repeat (200) @(posedge clock_i);
    endtask : cfg
    task automatic measure(input int n);
        hi = 16'h0;
        evs = 16'h0;
        repeat (n) begin
            @(posedge clock_i);
            #1;
            hi = hi + {15'h0, tout};
            evs = evs + {15'h0, ev};
        end
    endtask : measure

    task automatic t_regs();
        logic [7:0] v [4] = '{8'h0E, 8'hA5, 8'h3C, 8'h5A};
        logic [7:0] d;
        for (int a = 0; a < 4; a++) begin
            rd(a[1:0], d);
            chk("reset value", 16'h0, {8'h0, d});
            wr(a[1:0], v[a]);
        end
        for (int a = 0; a < 4; a++) begin
            rd(a[1:0], d);
            chk("read back", {8'h0, v[a]}, {8'h0, d});
        end
        $display("register test done");
    endtask : t_regs
    task automatic t_period();
        logic [7:0] k [3] = '{8'd1, 8'd3, 8'd9};
        for (int i = 0; i < 3; i++) begin
            cfg(8'h10, 8'h00, k[i]);
            measure(80);
            chk("period high", 16'd40, hi);
            chk("period events", 16'(80 / (k[i] + 1)), evs);
        end
        $display("period test done");
    endtask : t_period
    task automatic t_scale();
        logic [7:0]  s [5] = '{8'h01, 8'h21, 8'h41, 8'h61, 8'h1F};
        logic [15:0] e [5] = '{16'd256, 16'd64, 16'd16, 16'd4, 16'd16};
        for (int i = 0; i < 5; i++) begin
            cfg(8'h10, s[i], 8'h00);
            measure(512);
            chk("scaled events", e[i], evs);
            chk("scaled high", 16'd256, hi);
        end
        $display("scaler test done");
    endtask : t_scale
    task automatic t_pwm();
        logic [7:0]  s [6] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h00};
        logic [7:0]  k [6] = '{8'h09, 8'hFF, 8'h00, 8'h1F, 8'h3F, 8'h00};
        logic [15:0] e [6] = '{16'd20, 16'd512, 16'd8, 16'd256, 16'd512, 16'd2};
        for (int i = 0; i < 6; i++) begin
            cfg(8'h12, s[i], k[i]);
            measure(512);
            chk("pwm high", e[i], hi);
            chk("pwm events", 16'd0, evs);
        end
        $display("pwm test done");
    endtask : t_pwm
    task automatic t_gate();
        logic [2:0] oe;
        @(posedge clock_i);
        gate_opt <= 1'b1;
        comp_lvl <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            oe = (s == 0) ? 3'b000 : 3'(1 << (s - 1));
            cfg({4'h1, s[1:0], 2'b11}, 8'h00, 8'hFF);
            measure(64);
            chk("gated high", 16'd0, hi);
            chk("pin enable", {13'h0, oe}, {13'h0, pin_oe});
            chk("pin level", {13'h0, ~oe}, {13'h0, pin_level});
        end
        @(posedge clock_i);
        comp_lvl <= 1'b0;
        repeat (4) @(posedge clock_i);
        measure(64);
        chk("resumed high", 16'd64, hi);
        chk("pin level", 16'h7, {13'h0, pin_level});
        @(posedge clock_i);
        gate_opt <= 1'b0;
        comp_lvl <= 1'b1;
        repeat (4) @(posedge clock_i);
        measure(64);
        chk("ungated high", 16'd64, hi);
        $display("gating test done");
    endtask : t_gate
    task automatic t_freeze();
        logic [7:0] a, b;
        cfg(8'h10, 8'h00, 8'hFF);
        rd(2'h2, a);
        @(posedge clock_i);
        ce <= 1'b0;
        repeat (50) @(posedge clock_i);
        ce <= 1'b1;
        rd(2'h2, b);
        chk("frozen advance", 16'd3, {8'h0, b - a});
        $display("freeze test done");
    endtask : t_freeze
    task automatic t_source();
        logic [3:0] code [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                                  4'h1, 4'h2};
        logic       hlt  [11] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1};
        logic [7:0] e    [11] = '{8'd0, 8'd224, 8'd120, 8'd20, 8'd60, 8'd30, 8'd15, 8'd10,
                                  8'd0, 8'd0, 8'd120};
        logic [7:0] a, b;
        @(posedge clock_i);
        comp_tog <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            @(posedge clock_i);
            halt <= hlt[i];
            cfg({code[i], 4'h0}, 8'h00, 8'hFF);
            rd(2'h2, a);
            repeat (478) @(posedge clock_i);
            rd(2'h2, b);
            chk("count advance", {8'h0, e[i]}, {8'h0, b - a});
        end
        $display("source test done");
    endtask : t_source

    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 2'h0;
        wdata_i = 8'h00;
        halt = 1'b0;
        ce = 1'b1;
        gate_opt = 1'b0;
        comp_tog = 1'b0;
        comp_lvl = 1'b0;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        t_regs();
        t_period();
        t_scale();
        t_pwm();
        t_gate();
        t_freeze();
        t_source();
        print_verdict();
    end
endmodule : tmr_timer_tb
